//--- include/twm_map.svh
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TWM_A_CTRL 8'h00
`define TWM_A_STAT 8'h04
`define TWM_A_DATA 8'h08
`define TWM_A_ISTS 8'h0c
`define TWM_A_IMSK 8'h10

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define TWM_B_DONE 7
`define TWM_B_ACKE 6
`define TWM_B_STA 5
`define TWM_B_STO 4
`define TWM_B_WC 3
`define TWM_B_EN 2
`define TWM_B_IE 0

// ----------------------------------------
// Interrupt status and mask bit positions
// ----------------------------------------
`define TWM_I_DONE 0
`define TWM_I_WC 1
`define TWM_I_LOST 2
`define TWM_I_W 3

// ----------------------------------------
// Status codes, prescaler bits taken as zero
// ----------------------------------------
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_D_ACK 8'h28
`define TWM_ST_D_NACK 8'h30
`define TWM_ST_LOST 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_IDLE 8'hf8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TWM_CTRL_RST 8'h00
`define TWM_STAT_RST 8'hf8
`define TWM_DATA_RST 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define TWM_CLK_NS 50
`define TWM_QTR_NS 2500
`define TWM_QTR_CYC ((`TWM_QTR_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS)

`endif

//--- include/twm_pkg.sv
package twm_pkg;

  typedef enum logic [1:0] {
    TWM_OP_START = 2'b00,
    TWM_OP_BYTE = 2'b01,
    TWM_OP_STOP = 2'b10
  } twm_op_t;

  typedef enum logic [1:0] {
    TWM_S_IDLE = 2'b00,
    TWM_S_WAIT = 2'b01,
    TWM_S_RUN = 2'b11,
    TWM_S_HOLD = 2'b10
  } twm_state_t;

  typedef enum logic [1:0] {
    TWM_P0 = 2'b00,
    TWM_P1 = 2'b01,
    TWM_P2 = 2'b11,
    TWM_P3 = 2'b10
  } twm_phase_t;

endpackage : twm_pkg

//--- include/twm_eng_if.sv
`timescale 1ns/1ps
`default_nettype none

interface twm_eng_if;
  logic go;
  twm_pkg::twm_op_t op;
  logic [7:0] tx_byte;
  logic en;
  logic done;
  logic nack;
  logic lost;
  logic busy;

  modport ctl (output go, op, tx_byte, en, input done, nack, lost, busy);
  modport eng (input go, op, tx_byte, en, output done, nack, lost, busy);
endinterface : twm_eng_if

`default_nettype wire

//--- rtl/twm_bit_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.svh"

module twm_bit_engine #(
  parameter int QTR_CYC = `TWM_QTR_CYC
) (
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe,
  // Controller side
  twm_eng_if.eng eng
);
  localparam int CW = $clog2(QTR_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(QTR_CYC - 1);

  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_prev;
  logic sda_prev;
  logic busy;
  logic act;
  logic done;
  logic nack;
  logic lost;
  logic [CW-1:0] cnt;
  logic [3:0] bitn;
  logic [7:0] sh;
  twm_pkg::twm_op_t op_q;
  twm_pkg::twm_phase_t ph;
  logic tick;
  logic stall;

  // ----------------------------------------
  // Pin synchronisers and bus-free watch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (ce) begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_prev <= scl_s[1];
      sda_prev <= sda_s[1];
    end
  end

  // Any START on the wire marks the bus busy, any STOP frees it
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (ce) begin
      if (scl_prev && scl_s[1] && sda_prev && !sda_s[1]) begin
        busy <= 1'b1;
      end else if (scl_prev && scl_s[1] && !sda_prev && sda_s[1]) begin
        busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Quarter-bit sequencer
  // ----------------------------------------
  assign tick = (cnt == CNT_LAST);
  // A slave holding the clock low stretches the high phase
  assign stall = (ph == twm_pkg::TWM_P2) && !scl_s[1];

  always_ff @(posedge clk) begin
    if (rst) begin
      act <= 1'b0;
      ph <= twm_pkg::TWM_P0;
      cnt <= '0;
      bitn <= 4'h0;
      sh <= 8'h00;
      op_q <= twm_pkg::TWM_OP_START;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      lost <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!eng.en) begin
        act <= 1'b0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else if (eng.go && !act) begin
        act <= 1'b1;
        ph <= twm_pkg::TWM_P0;
        cnt <= '0;
        bitn <= 4'h0;
        sh <= eng.tx_byte;
        op_q <= eng.op;
        nack <= 1'b0;
        lost <= 1'b0;
      end else if (act && !stall) begin
        if (!tick) begin
          cnt <= cnt + 1'b1;
        end else begin
          cnt <= '0;
          case (ph)
            twm_pkg::TWM_P0: begin
              ph <= twm_pkg::TWM_P1;
              case (op_q)
                twm_pkg::TWM_OP_START: sda_oe <= 1'b0;
                twm_pkg::TWM_OP_STOP: sda_oe <= 1'b1;
                default: sda_oe <= (bitn == 4'h8) ? 1'b0 : !sh[7]; // R19
              endcase
            end
            twm_pkg::TWM_P1: begin
              ph <= twm_pkg::TWM_P2;
              scl_oe <= 1'b0;
            end
            twm_pkg::TWM_P2: begin
              ph <= twm_pkg::TWM_P3;
              case (op_q)
                twm_pkg::TWM_OP_START: sda_oe <= 1'b1;
                twm_pkg::TWM_OP_STOP: sda_oe <= 1'b0;
                default: begin
                  if (bitn == 4'h8) begin
                    nack <= sda_s[1]; // R19
                  end else if (!sda_oe && !sda_s[1]) begin
                    lost <= 1'b1;
                    act <= 1'b0;
                    done <= 1'b1;
                  end
                end
              endcase
            end
            twm_pkg::TWM_P3: begin
              ph <= twm_pkg::TWM_P0;
              if (op_q == twm_pkg::TWM_OP_STOP) begin
                act <= 1'b0;
                done <= 1'b1;
              end else begin
                // Clock stays low after a byte: the transfer is held
                scl_oe <= 1'b1; // R9
                if (op_q == twm_pkg::TWM_OP_START || bitn == 4'h8) begin
                  act <= 1'b0;
                  done <= 1'b1;
                end else begin
                  bitn <= bitn + 1'b1;
                  sh <= {sh[6:0], 1'b0};
                end
              end
            end
            default: ph <= twm_pkg::TWM_P0;
          endcase
        end
      end
    end
  end

  assign eng.done = done;
  assign eng.nack = nack;
  assign eng.lost = lost;
  assign eng.busy = busy;

endmodule : twm_bit_engine

`default_nettype wire

//--- rtl/twm_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.svh"

// Notes on behaviour
// [R1] START first; address direction picks the mode
// [R2] Software masks prescaler bits before comparing
// [R3] START request: flag, start, enable written one
// [R4] START waits until the bus is free
// [R5] After START: flag set, code 08
// [R6] Load address byte, then clear flag
// [R7] Address sent: flag set, code 18/20/38
// [R8] Data write with flag low: dropped, collision
// [R9] Transfer suspended while the flag is set
// [R10] STOP request: flag, stop, enable written one
// [R11] Repeated START: flag, start, enable written one
// [R12] Repeated START keeps the bus owned
// [R13] At 08, cleared flag sends address byte
// [R14] Read bit after 10 selects receive mode
// [R15] At 18/20: byte, rSTART, STOP, STOP+START
// [R16] Stop request bit self-clears once sent
// [R17] At 28, cleared flag sends next byte
// [R18] At 38: release bus, or queue START
// [R19] Open-drain lines; acknowledge on ninth clock
module twm_master #(
  parameter int QTR_CYC = `TWM_QTR_CYC
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // APB slave
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ,
  // Two-wire bus
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);
  twm_eng_if eng ();

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic flag;
  logic acke;
  logic sta;
  logic sto;
  logic wc;
  logic en;
  logic ie;
  logic [7:0] code;
  logic [1:0] presc;
  logic [7:0] data;
  logic [`TWM_I_W-1:0] ists;
  logic [`TWM_I_W-1:0] imsk;

  // ----------------------------------------
  // Sequencing state
  // ----------------------------------------
  twm_pkg::twm_state_t state;
  twm_pkg::twm_op_t op;
  logic go;
  logic owner;
  logic addr_phase;
  logic mode_rx;
  logic pend_start;
  logic set_flag;
  logic sto_clr;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic wr;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic wr_ists;
  logic wr_imsk;
  logic mapped;
  logic go_cmd;
  logic [7:0] ctrl_rd;
  logic [31:0] rd_mux;

  assign wr = PSEL && PENABLE && PWRITE && CE;
  assign wr_ctrl = wr && hit(PADDR, `TWM_A_CTRL);
  assign wr_stat = wr && hit(PADDR, `TWM_A_STAT);
  assign wr_data = wr && hit(PADDR, `TWM_A_DATA);
  assign wr_ists = wr && hit(PADDR, `TWM_A_ISTS);
  assign wr_imsk = wr && hit(PADDR, `TWM_A_IMSK);
  assign mapped = hit(PADDR, `TWM_A_CTRL) || hit(PADDR, `TWM_A_STAT)
    || hit(PADDR, `TWM_A_DATA) || hit(PADDR, `TWM_A_ISTS)
    || hit(PADDR, `TWM_A_IMSK);
  // Writing one to the flag with enable set resumes the sequencer
  assign go_cmd = wr_ctrl && PWDATA[`TWM_B_DONE] && PWDATA[`TWM_B_EN]; // R3 R10 R11

  // No wait states; a frozen block holds the master off
  assign PREADY = CE;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  assign ctrl_rd = {flag, acke, sta, sto, wc, en, 1'b0, ie};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(PADDR, `TWM_A_CTRL)) begin
      rd_mux[7:0] = ctrl_rd;
    end else if (hit(PADDR, `TWM_A_STAT)) begin
      // Code sits in the upper bits so masking the prescaler leaves it intact
      rd_mux[7:0] = code | {6'h00, presc}; // R2
    end else if (hit(PADDR, `TWM_A_DATA)) begin
      rd_mux[7:0] = data;
    end else if (hit(PADDR, `TWM_A_ISTS)) begin
      rd_mux[`TWM_I_W-1:0] = ists;
    end else if (hit(PADDR, `TWM_A_IMSK)) begin
      rd_mux[`TWM_I_W-1:0] = imsk;
    end
  end

  // Read data is captured in the setup phase so it stands registered
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (CE && PSEL && !PENABLE) begin
      PRDATA <= rd_mux;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = `TWM_CTRL_RST;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flag <= CTRL_RST[`TWM_B_DONE];
    end else if (CE) begin
      if (set_flag) begin
        flag <= 1'b1; // R5 R7
      end else if (wr_ctrl && PWDATA[`TWM_B_DONE]) begin
        flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      acke <= 1'b0;
      sta <= 1'b0;
      en <= 1'b0;
      ie <= 1'b0;
    end else if (CE && wr_ctrl) begin
      acke <= PWDATA[`TWM_B_ACKE];
      sta <= PWDATA[`TWM_B_STA];
      en <= PWDATA[`TWM_B_EN];
      ie <= PWDATA[`TWM_B_IE];
    end
  end

  // A software write lands after the hardware clear of the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sto <= 1'b0;
    end else if (CE) begin
      if (wr_ctrl) begin
        sto <= PWDATA[`TWM_B_STO];
      end else if (sto_clr) begin
        sto <= 1'b0; // R16
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wc <= 1'b0;
    end else if (CE) begin
      if (wr_data && !flag) begin
        wc <= 1'b1; // R8
      end else if (wr_data) begin
        wc <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Data and status registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      data <= `TWM_DATA_RST;
    end else if (CE && wr_data && flag) begin
      data <= PWDATA[7:0]; // R8
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      presc <= 2'h0;
    end else if (CE && wr_stat) begin
      presc <= PWDATA[1:0];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ists <= '0;
      imsk <= '0;
    end else if (CE) begin
      for (int i = 0; i < `TWM_I_W; i++) begin
        if (wr_ists && PWDATA[i]) begin
          ists[i] <= 1'b0;
        end
      end
      if (set_flag) begin
        ists[`TWM_I_DONE] <= 1'b1;
      end
      if (wr_data && !flag) begin
        ists[`TWM_I_WC] <= 1'b1;
      end
      if (eng.done && eng.lost) begin
        ists[`TWM_I_LOST] <= 1'b1;
      end
      if (wr_imsk) begin
        imsk <= PWDATA[`TWM_I_W-1:0];
      end
    end
  end

  assign IRQ = |(ists & imsk);

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= twm_pkg::TWM_S_IDLE;
      op <= twm_pkg::TWM_OP_START;
      go <= 1'b0;
      owner <= 1'b0;
      addr_phase <= 1'b0;
      mode_rx <= 1'b0;
      pend_start <= 1'b0;
      set_flag <= 1'b0;
      sto_clr <= 1'b0;
      code <= `TWM_STAT_RST;
    end else if (CE) begin
      go <= 1'b0;
      set_flag <= 1'b0;
      sto_clr <= 1'b0;
      // The enable written with a START lands in this same cycle, so the
      // registered enable alone would drop that first START
      if (!en && !go_cmd) begin
        state <= twm_pkg::TWM_S_IDLE;
        owner <= 1'b0;
        pend_start <= 1'b0;
      end else begin
        case (state)
          twm_pkg::TWM_S_IDLE: begin
            if (go_cmd && PWDATA[`TWM_B_STA]) begin
              state <= twm_pkg::TWM_S_WAIT; // R1
            end
          end
          twm_pkg::TWM_S_WAIT: begin
            if (!eng.busy) begin
              op <= twm_pkg::TWM_OP_START; // R4
              go <= 1'b1;
              pend_start <= 1'b0;
              state <= twm_pkg::TWM_S_RUN;
            end
          end
          twm_pkg::TWM_S_RUN: begin
            if (eng.done) begin
              case (op)
                twm_pkg::TWM_OP_START: begin
                  code <= owner ? `TWM_ST_RSTART : `TWM_ST_START; // R5 R12
                  owner <= 1'b1;
                  addr_phase <= 1'b1;
                  mode_rx <= 1'b0;
                  set_flag <= 1'b1;
                  state <= twm_pkg::TWM_S_HOLD;
                end
                twm_pkg::TWM_OP_STOP: begin
                  code <= `TWM_ST_IDLE;
                  owner <= 1'b0;
                  sto_clr <= 1'b1; // R16
                  state <= pend_start ? twm_pkg::TWM_S_WAIT : twm_pkg::TWM_S_IDLE;
                end
                default: begin
                  addr_phase <= 1'b0;
                  set_flag <= 1'b1;
                  state <= twm_pkg::TWM_S_HOLD;
                  if (eng.lost) begin
                    code <= `TWM_ST_LOST; // R7
                    owner <= 1'b0;
                  end else if (addr_phase && data[0]) begin
                    code <= eng.nack ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK;
                    mode_rx <= 1'b1; // R1 R14
                  end else if (addr_phase) begin
                    code <= eng.nack ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK; // R7
                  end else begin
                    code <= eng.nack ? `TWM_ST_D_NACK : `TWM_ST_D_ACK; // R17
                  end
                end
              endcase
            end
          end
          twm_pkg::TWM_S_HOLD: begin
            if (go_cmd) begin
              if (code == `TWM_ST_LOST) begin
                // Lines are already released; a START is queued for a free bus
                state <= PWDATA[`TWM_B_STA] ? twm_pkg::TWM_S_WAIT : twm_pkg::TWM_S_IDLE; // R18
              end else if (PWDATA[`TWM_B_STO]) begin
                op <= twm_pkg::TWM_OP_STOP; // R15
                go <= 1'b1;
                pend_start <= PWDATA[`TWM_B_STA];
                state <= twm_pkg::TWM_S_RUN;
              end else if (PWDATA[`TWM_B_STA]) begin
                op <= twm_pkg::TWM_OP_START; // R11 R15
                go <= 1'b1;
                state <= twm_pkg::TWM_S_RUN;
              end else if (!mode_rx) begin
                // Address byte after a START, data byte otherwise
                op <= twm_pkg::TWM_OP_BYTE; // R6 R13 R15 R17
                go <= 1'b1;
                state <= twm_pkg::TWM_S_RUN;
              end
              // Receive-mode byte transfers are not sequenced here
            end
          end
          default: state <= twm_pkg::TWM_S_IDLE;
        endcase
      end
    end
  end

  assign eng.go = go;
  assign eng.op = op;
  assign eng.tx_byte = data;
  assign eng.en = en;

  // ----------------------------------------
  // Bit engine and pins
  // ----------------------------------------
  twm_bit_engine #(
    .QTR_CYC(QTR_CYC)
  ) u_engine (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .scl_in(SCL_I),
    .sda_in(SDA_I),
    .scl_oe(SCL_OE),
    .sda_oe(SDA_OE),
    .eng(eng.eng)
  );

  // Open-drain: only ever pull low or let go
  assign SCL_O = 1'b0; // R19
  assign SDA_O = 1'b0; // R19

endmodule : twm_master

`default_nettype wire

//--- verif/twm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  // Behaviour
  input wire logic nack,
  output logic sda_oe
);
  int cnt = 0;
  int n_stop = 0;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx_q[$];
  initial sda_oe = 1'b0;
  always @(negedge sda) if (scl === 1'b1) cnt = 0;
  always @(posedge sda) if (scl === 1'b1) n_stop++;
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    cnt++;
  end
  // ----
  // Ack on ninth clock, line freed at its fall
  // ----
  always @(negedge scl) begin
    if (cnt == 8) begin
      sda_oe <= !nack;
      rx_q.push_back(sh);
    end else if (cnt == 9) begin
      sda_oe <= 1'b0;
      cnt = 0;
    end
  end
endmodule : twm_slave_model
`default_nettype wire

//--- verif/twm_master_checker.sv
`timescale 1ns/1ps
`default_nettype none
module twm_master_checker #(
  parameter int QTR_CYC = 2
) (
  // System
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // APB
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ,
  // Bus
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE
);
  localparam int START_MAX = 2 * QTR_CYC + 8;
  logic [7:0] n_low;
  logic sda_q;
  logic scl_q;
  logic acc;
  logic mapped;
  logic held;
  logic resumed;
  assign acc = PSEL && PENABLE && CE;
  assign mapped = PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  // Clock pulls since START; after START and each ninth bit SCL must hold
  assign held = n_low != 8'h00 && n_low % 9 == 1;
  always_ff @(posedge CLK_SYS) begin
    sda_q <= SDA_OE;
    scl_q <= SCL_OE;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      n_low <= 8'h00;
    end else if (SDA_OE && !sda_q && SCL_I) begin
      n_low <= 8'h00;
    end else if (SCL_OE && !scl_q) begin
      n_low <= n_low + 8'h01;
    end
  end
  // Any control write may release a held clock until it is pulled again
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      resumed <= 1'b0;
    end else if (acc && PWRITE && PADDR == 8'h00) begin
      resumed <= 1'b1;
    end else if (SCL_OE && !scl_q) begin
      resumed <= 1'b0;
    end
  end
  sequence s_start;
    $rose(SDA_OE) && SCL_I;
  endsequence
  sequence s_stop;
    $fell(SDA_OE) && SCL_I && !SCL_OE;
  endsequence
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_open_drain: assert property (!SCL_O && !SDA_O)
    else $error("bus line driven high");
  a_start_free: assert property (s_start |-> $past(SDA_I) && $past(SCL_I))
    else $error("start on busy lines");
  a_start_clock: assert property (s_start |-> ##[1:START_MAX] $rose(SCL_OE))
    else $error("start not followed by clock low");
  a_stop_idle: assert property (s_stop |=> !SDA_OE && !SCL_OE)
    else $error("lines pulled right after stop");
  a_scl_suspend: assert property (SCL_OE && held && !resumed
    && !(acc && PWRITE && PADDR == 8'h00) |=> SCL_OE)
    else $error("clock released while suspended");
  a_scl_high: assert property ($fell(SCL_OE) |-> !SCL_OE [*2])
    else $error("clock high too short");
  a_reset_lines: assert property (disable iff (1'b0) RST |=> !SCL_OE && !SDA_OE && !IRQ)
    else $error("lines or irq active after reset");
  a_ready_ce: assert property (PREADY == CE)
    else $error("ready differs from enable");
  a_slverr_map: assert property (acc |-> PSLVERR == !mapped)
    else $error("error response wrong");
  a_unmapped_zero: assert property (acc && !PWRITE && !mapped |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
endmodule : twm_master_checker
bind twm_master twm_master_checker #(.QTR_CYC(QTR_CYC)) u_chk (.CLK_SYS(CLK_SYS),
  .RST(RST), .CE(CE), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
  .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE));
`default_nettype wire

//--- verif/two_wire_master_transmit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.svh"
module two_wire_master_transmit_tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h0001_4c99;
  logic pready, pslverr, irq, scl_o, scl_oe, sda_o, sda_oe, s_oe, e, nack = 1'b0;
  logic [7:0] a;
  logic [7:0] exp_q[$];
  int n_errors = 0, num_checks = 0, i, s0;
  // Open-drain wires with pull-ups
  wire logic scl_w = !scl_oe;
  wire logic sda_w = !(sda_oe || s_oe);
  always #25 clk_sys = ~clk_sys;
  // QTR_CYC of 2 gives a 500 ns bus clock, two synchroniser cycles stretching each high phase
  twm_master #(.QTR_CYC(2)) u_dut (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .PADDR(paddr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .SCL_I(scl_w), .SCL_O(scl_o),
    .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe));
  twm_slave_model u_slv (.scl(scl_w), .sda(sda_w), .nack(nack), .sda_oe(s_oe));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // ----
  // APB master
  // ----
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
      output logic [31:0] rv, output logic ev);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [31:0] rv;
    logic ev;
    apb(1'b1, ad, {24'h0, d}, rv, ev);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] x);
    logic ev;
    apb(1'b0, ad, 32'h0, r, ev);
    check(r, {24'h0, x});
  endtask : rd_chk
  task automatic poll(input int bitn, input logic val);
    int k;
    for (k = 0; k < 300; k++) begin
      apb(1'b0, `TWM_A_CTRL, 32'h0, r, e);
      if (r[bitn] === val) break;
    end
    if (k == 300) begin
      n_errors++;
      stop_test();
    end
  endtask : poll
  task automatic resume(input logic [7:0] c, input logic [7:0] st);
    wr(`TWM_A_CTRL, c);
    poll(`TWM_B_DONE, 1'b1);
    rd_chk(`TWM_A_STAT, st);
  endtask : resume
  // ----
  // Byte send with a colliding write while busy
  // ----
  task automatic send(input logic [7:0] b, input logic adr, input logic nk);
    logic [7:0] st;
    st = adr ? (b[0] ? (nk ? 8'h48 : 8'h40) : (nk ? 8'h20 : 8'h18)) : (nk ? 8'h30 : 8'h28);
    nack <= nk;
    exp_q.push_back(b);
    wr(`TWM_A_DATA, b);
    wr(`TWM_A_CTRL, 8'h84);
    wr(`TWM_A_DATA, ~b);
    poll(`TWM_B_DONE, 1'b1);
    check(r[`TWM_B_WC], 1'b1);
    rd_chk(`TWM_A_STAT, st);
    rd_chk(`TWM_A_DATA, b);
    check(u_slv.rx_q.pop_front(), exp_q.pop_front());
  endtask : send
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(`TWM_A_CTRL, `TWM_CTRL_RST);
    rd_chk(`TWM_A_STAT, `TWM_STAT_RST);
    rd_chk(`TWM_A_DATA, `TWM_DATA_RST);
    rd_chk(`TWM_A_IMSK, 8'h00);
    wr(`TWM_A_STAT, 8'h03);
    apb(1'b0, `TWM_A_STAT, 32'h0, r, e);
    check(r & 32'h0000_00f8, `TWM_STAT_RST);
    check(r[1:0], 2'h3);
    wr(`TWM_A_STAT, 8'h00);
    apb(1'b0, 8'h14, 32'h0, r, e);
    check(e, 1'b1);
    check(r, 32'h0);
    wr(`TWM_A_DATA, 8'h3c);
    rd_chk(`TWM_A_CTRL, 8'h08);
    rd_chk(`TWM_A_DATA, `TWM_DATA_RST);
    rd_chk(`TWM_A_ISTS, 8'h02);
    @(negedge clk_sys);
    check(irq, 1'b0);
    wr(`TWM_A_IMSK, 8'h07);
    @(negedge clk_sys);
    check(irq, 1'b1);
    wr(`TWM_A_ISTS, 8'h07);
    @(negedge clk_sys);
    check(irq, 1'b0);
    resume(8'ha4, `TWM_ST_START);
    check(irq, 1'b1);
    a = rnd();
    send({a[6:0], 1'b0}, 1'b1, 1'b0);
    for (i = 0; i < 3; i++) send(rnd(), 1'b0, i == 2);
    resume(8'ha4, `TWM_ST_RSTART);
    send({a[6:0] ^ 7'h01, 1'b0}, 1'b1, 1'b1);
    s0 = u_slv.n_stop;
    resume(8'hb4, `TWM_ST_START);
    apb(1'b0, `TWM_A_CTRL, 32'h0, r, e);
    check(r[`TWM_B_STO], 1'b0);
    send({a[6:0], 1'b0}, 1'b1, 1'b0);
    wr(`TWM_A_CTRL, 8'h94);
    poll(`TWM_B_STO, 1'b0);
    rd_chk(`TWM_A_STAT, `TWM_ST_IDLE);
    check(u_slv.n_stop - s0, 2);
    resume(8'ha4, `TWM_ST_START);
    send({a[6:0], 1'b1}, 1'b1, 1'b0);
    wr(`TWM_A_CTRL, 8'h00);
    stop_test();
  end
endmodule : two_wire_master_transmit_tb_top
`default_nettype wire
